// ---- design/fssp_pkg.sv ----
/*
  fssp_pkg: register indices, field positions, reset values, state and
  status types for the flash sector status and protection block.
  assumes: apb byte address = register index * 4, 32-bit data, 16 bits used.
*/
package fssp_pkg;
  // register indices (byte address is index * 4)
  localparam int          ADDR_W           = 24;
  localparam int          IDX_W            = 22;
  localparam logic [21:0] IDX_OP_CONTROL   = 22'h0E0002;
  localparam logic [21:0] IDX_SECTOR_SEL   = 22'h0E0004;
  localparam logic [21:0] IDX_STATUS_HIGH  = 22'h0E0006;
  localparam logic [21:0] IDX_DATA_LOW     = 22'h0E0008;
  localparam logic [21:0] IDX_DATA_HIGH    = 22'h0E000A;
  localparam logic [21:0] IDX_IRQ_STATUS   = 22'h0E0010;
  localparam logic [21:0] IDX_IRQ_MASK     = 22'h0E0012;
  localparam logic [21:0] IDX_PROT_EXT_B3  = 22'h0EDFB2;
  localparam logic [21:0] IDX_PROT_INT_B0  = 22'h0EDFB4;
  localparam logic [21:0] IDX_PROT_INT_B1  = 22'h0EDFB6;
  // control register fields
  localparam int          CTL_VIEW         = 0;
  localparam int          CTL_ERASE        = 1;
  localparam int          CTL_SET_PROT     = 2;
  localparam int          CTL_SUSPEND      = 3;
  localparam int          CTL_START        = 4;
  // sector select fields
  localparam int          SEL_B0_LO        = 0;
  localparam int          SEL_B0_HI        = 9;
  localparam int          SEL_B1_LO        = 10;
  localparam int          SEL_B2_LO        = 12;
  localparam int          SEL_B3_LO        = 14;
  // op data fields used by set protection
  localparam int          DHI_INT_B1_LO    = 0;
  localparam int          DHI_EXT_B3_LO    = 8;
  // interrupt events
  localparam int          EV_W             = 3;
  localparam int          EV_ERASE_OK      = 0;
  localparam int          EV_ERASE_ERR     = 1;
  localparam int          EV_PROT_DONE     = 2;
  // reset and delivery values
  localparam logic [15:0] RST_STATUS       = 16'h0000;
  localparam logic [15:0] RST_REG          = 16'h0000;
  localparam logic [15:0] DELIVERY_PROT    = 16'hFFFF;
  localparam logic [15:0] PROT_MASK_B0     = 16'h03FF;
  localparam logic [15:0] PROT_MASK_2      = 16'h0003;
  localparam logic [31:0] PRDATA_ZERO      = 32'h00000000;

  // per-array status: bank pair and two sector flags
  typedef struct packed {
    logic [1:0] bank;
    logic [1:0] sect;
  } fssp_stat_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROTECT} fssp_state_t;

  // status word: banks at 9:8, sectors at 1:0, reserved read zero
  function automatic logic [15:0] fssp_view(input fssp_stat_t s);
    fssp_view = {6'h00, s.bank, 6'h00, s.sect};
  endfunction : fssp_view
endpackage : fssp_pkg

// ---- design/fssp_top.sv ----
/*
  fssp_top: apb register slave for flash erase sector selection, per-sector
  and per-bank erase status, non-volatile write protection, set-protection
  and suspend handling, with a maskable interrupt.
  assumes: single clock, FLASH_ERR comes asynchronously from the array.
*/
// Summary of operation
// [R1] sector select picks erase targets; status high reports sector and bank state
// [R2] view select bit picks external (0) or internal (1) array status
// [R3] external view: bits 1:0 set during erase for bank 3 sectors 1:0
// [R4] external view: bits 9:8 updated during erase for banks 3 and 2
// [R5] internal view: bits 1:0 show erase status of bank 1 sectors 1:0
// [R6] internal view: bits 9:8 updated during erase for banks 1 and 0
// [R7] status clears on error-free erase end, kept when an error occurred
// [R8] status high resets to zero, unused bits read as reserved zero
// [R9] external bank 3 protect bits at 0 block writes to sectors 1:0
// [R10] internal bank 0 protect bits 9:0 at 0 block their sectors
// [R11] internal bank 1 protect bits 1:0 at 0 block their sectors
// [R12] protection registers deliver as all ones, nothing protected
// [R13] set protection: select bit, data low/high, then start bit
// [R14] suspend acts on the select bit alone, no start needed
// [R15] software writes never change the status high bits
`timescale 1ns/100ps
`default_nettype none
module fssp_top
  import fssp_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = 1000,
  parameter int unsigned PROT_CYCLES  = 100
) (
  // clock, reset, enable
  input  wire  logic              CLK_SYS,
  input  wire  logic              RST,
  input  wire  logic              CE,
  // apb slave
  input  wire  logic              PSEL,
  input  wire  logic              PENABLE,
  input  wire  logic              PWRITE,
  input  wire  logic [ADDR_W-1:0] PADDR,
  input  wire  logic [31:0]       PWDATA,
  output var   logic [31:0]       PRDATA,
  output var   logic              PREADY,
  output var   logic              PSLVERR,
  // flash array
  input  wire  logic              FLASH_ERR,
  output var   logic              BUSY,
  output var   logic              SUSPENDED,
  output var   logic [15:0]       ERASE_SECTORS,
  output var   logic [1:0]        EXT_BANK3_PROTECT_BITS,
  output var   logic [9:0]        INT_BANK0_PROTECT_BITS,
  output var   logic [1:0]        INT_BANK1_PROTECT_BITS,
  // interrupt
  output var   logic              IRQ
);

  fssp_state_t        state;
  fssp_state_t        next_state;
  fssp_stat_t         stat_ext;
  fssp_stat_t         stat_int;
  fssp_stat_t         next_stat_ext;
  fssp_stat_t         next_stat_int;
  logic               err_meta;
  logic               err_sync;
  logic               err_seen;
  logic               array_view_select;
  logic               erase_select;
  logic               set_protection_select;
  logic               suspend_select;
  logic [15:0]        flash_sector_select_low;
  logic [15:0]        op_data_low;
  logic [15:0]        op_data_high;
  logic [15:0]        nv_protect_ext_bank3;
  logic [15:0]        nv_protect_int_bank0;
  logic [15:0]        nv_protect_int_bank1;
  logic [EV_W-1:0]    irq_status;
  logic [EV_W-1:0]    irq_mask;
  logic [EV_W-1:0]    next_irq_status;
  logic [31:0]        cnt;

  // bus decode
  wire logic [IDX_W-1:0] idx        = PADDR[ADDR_W-1:2];
  wire logic sel_ctl    = idx == IDX_OP_CONTROL;
  wire logic sel_sect   = idx == IDX_SECTOR_SEL;
  wire logic sel_status = idx == IDX_STATUS_HIGH;
  wire logic sel_dlo    = idx == IDX_DATA_LOW;
  wire logic sel_dhi    = idx == IDX_DATA_HIGH;
  wire logic sel_irqs   = idx == IDX_IRQ_STATUS;
  wire logic sel_irqm   = idx == IDX_IRQ_MASK;
  wire logic sel_p3     = idx == IDX_PROT_EXT_B3;
  wire logic sel_p0     = idx == IDX_PROT_INT_B0;
  wire logic sel_p1     = idx == IDX_PROT_INT_B1;
  wire logic hit        = sel_ctl | sel_sect | sel_status | sel_dlo | sel_dhi
                        | sel_irqs | sel_irqm | sel_p3 | sel_p0 | sel_p1;
  wire logic rd_cap     = CE & PSEL & PENABLE & ~PREADY;
  wire logic done_xfer  = CE & PSEL & PENABLE & PREADY;
  wire logic wr_fire    = done_xfer & PWRITE & hit;
  wire logic rd_fire    = done_xfer & ~PWRITE;
  wire logic busy_now   = state != ST_IDLE;

  // read mux
  wire logic [15:0] status_word = array_view_select ? fssp_view(stat_int)   // R2
                                                    : fssp_view(stat_ext);
  wire logic [15:0] ctl_word    = {11'h000, busy_now, suspend_select,
                                   set_protection_select, erase_select,
                                   array_view_select};
  wire logic [15:0] rd_word =
      sel_ctl    ? ctl_word :
      sel_sect   ? flash_sector_select_low :
      sel_status ? status_word :
      sel_dlo    ? op_data_low :
      sel_dhi    ? op_data_high :
      sel_irqs   ? {13'h0000, irq_status} :
      sel_irqm   ? {13'h0000, irq_mask} :
      sel_p3     ? nv_protect_ext_bank3 :
      sel_p0     ? nv_protect_int_bank0 :
      sel_p1     ? nv_protect_int_bank1 : RST_REG;

  // protection map in sector select layout, bank 2 has no protection
  wire logic [15:0] prot_map = {nv_protect_ext_bank3[1:0], 2'b11,              // R9
                                nv_protect_int_bank1[1:0],                     // R11
                                nv_protect_int_bank0[SEL_B0_HI:SEL_B0_LO]};    // R10
  wire logic [15:0] sect_sel   = flash_sector_select_low;
  wire logic        prot_hit   = |(sect_sel & ~prot_map);

  // operation start and end
  wire logic wr_ctl      = wr_fire & sel_ctl;
  wire logic start_req   = wr_ctl & PWDATA[CTL_START] & ~busy_now;          // R13
  wire logic start_erase = start_req & PWDATA[CTL_ERASE];
  wire logic start_prot  = start_req & ~PWDATA[CTL_ERASE] & PWDATA[CTL_SET_PROT];
  wire logic running     = busy_now & ~suspend_select;                      // R14
  wire logic erase_end   = running & state == ST_ERASE
                         & cnt == 32'(ERASE_CYCLES - 1);
  wire logic prot_end    = running & state == ST_PROTECT
                         & cnt == 32'(PROT_CYCLES - 1);
  wire logic erase_fail  = err_seen | err_sync;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_erase) begin
          next_state = ST_ERASE;
        end else if (start_prot) begin
          next_state = ST_PROTECT;                                          // R13
        end
      end
      ST_ERASE: begin
        if (erase_end) begin
          next_state = ST_IDLE;
        end
      end
      ST_PROTECT: begin
        if (prot_end) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // status update, hardware only
  always_comb begin
    next_stat_ext = stat_ext;
    next_stat_int = stat_int;
    if (start_erase) begin
      next_stat_ext.sect = sect_sel[SEL_B3_LO +: 2];                        // R3
      next_stat_ext.bank = {|sect_sel[SEL_B3_LO +: 2],
                            |sect_sel[SEL_B2_LO +: 2]};                     // R4
      next_stat_int.sect = sect_sel[SEL_B1_LO +: 2];                        // R5
      next_stat_int.bank = {|sect_sel[SEL_B1_LO +: 2],
                            |sect_sel[SEL_B0_HI:SEL_B0_LO]};                // R6
    end else if (erase_end && !erase_fail) begin
      next_stat_ext = '0;                                                   // R7
      next_stat_int = '0;
    end
  end

  // events: read clears only the bits returned, set wins
  wire logic [EV_W-1:0] ev = {prot_end,
                              erase_end & erase_fail,
                              erase_end & ~erase_fail};
  wire logic [EV_W-1:0] rd_clr = (rd_fire & sel_irqs) ? PRDATA[EV_W-1:0] : '0;
  assign next_irq_status = (irq_status & ~rd_clr) | ev;

  // error pin synchroniser
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      err_meta <= 1'b0;
      err_sync <= 1'b0;
    end else if (CE) begin
      err_meta <= FLASH_ERR;
      err_sync <= err_meta;
    end
  end

  // apb answer, one wait state
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= PRDATA_ZERO;
    end else if (CE) begin
      PREADY  <= rd_cap;
      PSLVERR <= rd_cap & ~hit;
      if (rd_cap) begin
        PRDATA <= {16'h0000, rd_word};
      end
    end
  end

  // software registers; status high has no write path
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      array_view_select       <= 1'b0;
      erase_select            <= 1'b0;
      set_protection_select   <= 1'b0;
      suspend_select          <= 1'b0;
      flash_sector_select_low <= RST_REG;
      op_data_low             <= RST_REG;
      op_data_high            <= RST_REG;
      irq_mask                <= '0;
    end else if (CE && wr_fire) begin
      if (sel_ctl) begin
        array_view_select     <= PWDATA[CTL_VIEW];
        erase_select          <= PWDATA[CTL_ERASE];
        set_protection_select <= PWDATA[CTL_SET_PROT];
        suspend_select        <= PWDATA[CTL_SUSPEND];                       // R14
      end
      if (sel_sect && !busy_now) begin
        flash_sector_select_low <= PWDATA[15:0];                            // R1
      end
      if (sel_dlo) begin
        op_data_low <= PWDATA[15:0];                                        // R13
      end
      if (sel_dhi) begin
        op_data_high <= PWDATA[15:0];
      end
      if (sel_irqm) begin
        irq_mask <= PWDATA[EV_W-1:0];
      end
    end
  end

  // sequencer, status, error capture
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state    <= ST_IDLE;
      stat_ext <= fssp_stat_t'(RST_STATUS[3:0]);                            // R8
      stat_int <= fssp_stat_t'(RST_STATUS[3:0]);
      cnt      <= '0;
      err_seen <= 1'b0;
    end else if (CE) begin
      state    <= next_state;
      stat_ext <= next_stat_ext;                                            // R15
      stat_int <= next_stat_int;
      if (start_req || !busy_now) begin
        cnt <= '0;
      end else if (running) begin
        cnt <= cnt + 32'd1;                                                 // R14
      end
      if (start_erase) begin
        err_seen <= prot_hit;                                               // R9
      end else if (state == ST_ERASE && err_sync) begin
        err_seen <= 1'b1;
      end
    end
  end

  // non-volatile protection: programming can only clear bits
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      nv_protect_ext_bank3 <= DELIVERY_PROT;                                // R12
      nv_protect_int_bank0 <= DELIVERY_PROT;
      nv_protect_int_bank1 <= DELIVERY_PROT;
    end else if (CE && prot_end) begin
      nv_protect_int_bank0 <= nv_protect_int_bank0
                            & (op_data_low | ~PROT_MASK_B0);                // R10
      nv_protect_int_bank1 <= nv_protect_int_bank1
                            & ({14'h3FFF, op_data_high[DHI_INT_B1_LO +: 2]}
                               | ~PROT_MASK_2);                             // R11
      nv_protect_ext_bank3 <= nv_protect_ext_bank3
                            & ({14'h3FFF, op_data_high[DHI_EXT_B3_LO +: 2]}
                               | ~PROT_MASK_2);                             // R9
    end
  end

  // registered outputs
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      irq_status             <= '0;
      IRQ                    <= 1'b0;
      BUSY                   <= 1'b0;
      SUSPENDED              <= 1'b0;
      ERASE_SECTORS          <= RST_REG;
      EXT_BANK3_PROTECT_BITS <= DELIVERY_PROT[1:0];
      INT_BANK0_PROTECT_BITS <= DELIVERY_PROT[SEL_B0_HI:SEL_B0_LO];
      INT_BANK1_PROTECT_BITS <= DELIVERY_PROT[1:0];
    end else if (CE) begin
      irq_status             <= next_irq_status;
      IRQ                    <= |(next_irq_status & irq_mask);
      BUSY                   <= next_state != ST_IDLE;
      SUSPENDED              <= (next_state != ST_IDLE) & suspend_select;
      EXT_BANK3_PROTECT_BITS <= nv_protect_ext_bank3[1:0];
      INT_BANK0_PROTECT_BITS <= nv_protect_int_bank0[SEL_B0_HI:SEL_B0_LO];
      INT_BANK1_PROTECT_BITS <= nv_protect_int_bank1[1:0];
      if (start_erase) begin
        ERASE_SECTORS <= sect_sel & prot_map;                               // R9
      end else if (next_state != ST_ERASE) begin
        ERASE_SECTORS <= RST_REG;
      end
    end
  end

  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  property p_status_ro;
    wr_fire && sel_status && !busy_now |=> $stable(stat_ext) && $stable(stat_int);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status changed by write"); // R15

  property p_ext_set;
    start_erase |=> stat_ext.sect == $past(sect_sel[SEL_B3_LO +: 2])
                 && stat_ext.bank[0] == $past(|sect_sel[SEL_B2_LO +: 2]);
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("external status not set"); // R3

  property p_int_set;
    start_erase |=> stat_int.sect == $past(sect_sel[SEL_B1_LO +: 2])
                 && stat_int.bank[0] == $past(|sect_sel[SEL_B0_HI:SEL_B0_LO]);
  endproperty
  a_int_set: assert property (p_int_set) else $error("internal status not set"); // R5

  property p_clean_end;
    CE && erase_end && !erase_fail |=> stat_ext == '0 && stat_int == '0 && !BUSY;
  endproperty
  a_clean_end: assert property (p_clean_end) else $error("status not cleared"); // R7

  property p_fail_keep;
    CE && erase_end && erase_fail |=> $stable(stat_ext) && $stable(stat_int)
                              && irq_status[EV_ERASE_ERR];
  endproperty
  a_fail_keep: assert property (p_fail_keep) else $error("status lost on error"); // R7

  property p_view;
    rd_cap && sel_status |=> PRDATA[15:0] == ($past(array_view_select)
      ? fssp_view($past(stat_int)) : fssp_view($past(stat_ext)));
  endproperty
  a_view: assert property (p_view) else $error("wrong array view"); // R2

  property p_blocked;
    BUSY |-> (ERASE_SECTORS & ~prot_map) == 16'h0000;
  endproperty
  a_blocked: assert property (p_blocked) else $error("protected sector erased"); // R10

  property p_prot_only_clear;
    1'b1 |=> (nv_protect_int_bank0 & ~$past(nv_protect_int_bank0)) == 16'h0000
          && (nv_protect_ext_bank3 & ~$past(nv_protect_ext_bank3)) == 16'h0000;
  endproperty
  a_prot_only_clear: assert property (p_prot_only_clear) else $error("protection rose"); // R12

  property p_set_prot;
    start_prot |=> state == ST_PROTECT ##1 BUSY;
  endproperty
  a_set_prot: assert property (p_set_prot) else $error("set protection not started"); // R13

  property p_suspend;
    busy_now && suspend_select && CE |=> $stable(cnt) && busy_now;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend did not hold"); // R14

  property p_irq;
    CE && |(next_irq_status & irq_mask) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing"); // maskable interrupt

  c_erase_ok:  cover property (erase_end && !erase_fail);
  c_erase_err: cover property (erase_end && erase_fail);
  c_prot:      cover property (prot_end);
  c_suspend:   cover property (busy_now && suspend_select ##1 busy_now && !suspend_select);

endmodule : fssp_top
`default_nettype wire

// ---- bench/tb.sv ----
/*
  tb: self-checking bench for fssp_top, apb master, queue of expected answers.
  assumes: fssp_pkg compiled first; erase and protect counts shortened to 8 and 4.
*/
`timescale 1ns/100ps
`default_nettype none
module tb
  import fssp_pkg::*;
;
  typedef struct {logic [31:0] d; logic e; logic rd;} fssp_exp_t;

  logic              clk_sys;
  logic              rst;
  logic              ce;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              flash_err;
  logic              busy;
  logic              suspended;
  logic [15:0]       erase_sectors;
  logic [1:0]        p_ext;
  logic [9:0]        p_b0;
  logic [1:0]        p_b1;
  logic              irq;
  fssp_exp_t         expq[$];
  fssp_exp_t         mon_e;
  int                failures     = 0;
  int                total_checks = 0;
  int                cycles       = 0;

  fssp_top #(.ERASE_CYCLES(8), .PROT_CYCLES(4)) u_fssp_top (
    .CLK_SYS(clk_sys), .RST(rst), .CE(ce),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FLASH_ERR(flash_err), .BUSY(busy), .SUSPENDED(suspended), .ERASE_SECTORS(erase_sectors),
    .EXT_BANK3_PROTECT_BITS(p_ext), .INT_BANK0_PROTECT_BITS(p_b0),
    .INT_BANK1_PROTECT_BITS(p_b1), .IRQ(irq)
  );

  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic check_rd(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : check_rd

  task automatic check_pin(input logic [31:0] g, input logic [31:0] x);
    check_rd(g, x);
  endtask : check_pin

  // answer monitor: oldest note against each completed transfer
  always @(posedge clk_sys) begin
    if (pready === 1'h1) begin
      mon_e = expq.pop_front();
      check_rd({31'h0, pslverr}, {31'h0, mon_e.e});
      if (mon_e.rd === 1'h1)
        check_rd(prdata, mon_e.d);
    end
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic apb(input logic w, input logic [21:0] idx, input logic [15:0] v,
                     input logic [31:0] x, input logic ee, input logic chk);
    expq.push_back('{x, ee, chk});
    @(posedge clk_sys);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= {idx, 2'h0};
    pwdata  <= {16'h0000, v};
    @(posedge clk_sys);
    penable <= 1'h1;
    @(posedge clk_sys);
    while (pready !== 1'h1) @(posedge clk_sys);
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [21:0] idx, input logic [15:0] v);
    apb(1'h1, idx, v, 32'h0, 1'h0, 1'h0);
  endtask : wr

  task automatic rd(input logic [21:0] idx, input logic [31:0] x);
    apb(1'h0, idx, 16'h0, x, 1'h0, 1'h1);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic idle;
    tick(1);
    while (busy !== 1'h0) tick(1);
    tick(2);
  endtask : idle

  task automatic done_test(input string name);
    $display("test %s done", name);
  endtask : done_test

  initial begin
    logic [21:0] bad;
    rst       = 1'h1;
    ce        = 1'h1;
    psel      = 1'h0;
    penable   = 1'h0;
    pwrite    = 1'h0;
    paddr     = '0;
    pwdata    = 32'h0;
    flash_err = 1'h0;
    void'($urandom(5));
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    tick(1);
    // reset values, read-only places, unmapped index
    check_pin({18'h0, p_ext, p_b0, p_b1}, 32'h3FFF);
    rd(IDX_STATUS_HIGH, 32'h0);
    rd(IDX_PROT_EXT_B3, 32'hFFFF);
    rd(IDX_PROT_INT_B0, 32'hFFFF);
    rd(IDX_PROT_INT_B1, 32'hFFFF);
    wr(IDX_STATUS_HIGH, 16'($urandom));
    rd(IDX_STATUS_HIGH, 32'h0);
    bad = 22'h0E0100 + 22'($urandom % 256);
    apb(1'h1, bad, 16'($urandom), 32'h0, 1'h1, 1'h0);
    apb(1'h0, bad, 16'h0, 32'h0, 1'h1, 1'h0);
    done_test("reset");
    // external erase without error
    wr(IDX_IRQ_MASK, 16'h0007);
    wr(IDX_SECTOR_SEL, 16'h8000);
    wr(IDX_OP_CONTROL, 16'h0012);
    tick(1);
    check_pin({16'h0, erase_sectors}, 32'h8000);
    check_pin({31'h0, busy}, 32'h1);
    // clock enable low freezes the erase in place
    @(posedge clk_sys);
    ce <= 1'h0;
    tick(20);
    check_pin({15'h0, busy, erase_sectors}, 32'h18000);
    @(posedge clk_sys);
    ce <= 1'h1;
    rd(IDX_STATUS_HIGH, 32'h0202);
    idle();
    check_pin({31'h0, irq}, 32'h1);
    rd(IDX_STATUS_HIGH, 32'h0);
    rd(IDX_IRQ_STATUS, 32'h1);
    tick(2);
    check_pin({31'h0, irq}, 32'h0);
    done_test("erase_ok");
    // internal erase with array error and suspend
    wr(IDX_SECTOR_SEL, 16'h0408);
    wr(IDX_OP_CONTROL, 16'h0013);
    flash_err <= 1'h1;
    wr(IDX_OP_CONTROL, 16'h000B);
    tick(2);
    check_pin({30'h0, busy, suspended}, 32'h3);
    rd(IDX_STATUS_HIGH, 32'h0301);
    wr(IDX_OP_CONTROL, 16'h0003);
    flash_err <= 1'h0;
    idle();
    rd(IDX_STATUS_HIGH, 32'h0301);
    rd(IDX_IRQ_STATUS, 32'h2);
    wr(IDX_OP_CONTROL, 16'h0000);
    rd(IDX_STATUS_HIGH, 32'h0);
    done_test("erase_err");
    // set protection: select alone does nothing, start applies data
    wr(IDX_DATA_LOW, 16'h03F7);
    wr(IDX_DATA_HIGH, 16'h01FE);
    wr(IDX_OP_CONTROL, 16'h0004);
    tick(8);
    check_pin({18'h0, p_ext, p_b0, p_b1}, 32'h3FFF);
    wr(IDX_OP_CONTROL, 16'h0014);
    idle();
    check_pin({18'h0, p_ext, p_b0, p_b1}, 32'h1FDE);
    rd(IDX_PROT_EXT_B3, 32'hFFFD);
    rd(IDX_PROT_INT_B0, 32'hFFF7);
    rd(IDX_PROT_INT_B1, 32'hFFFE);
    rd(IDX_IRQ_STATUS, 32'h4);
    done_test("protect");
    // erases touching protected sectors
    wr(IDX_SECTOR_SEL, 16'h0018);
    wr(IDX_OP_CONTROL, 16'h0013);
    tick(1);
    check_pin({16'h0, erase_sectors}, 32'h0010);
    idle();
    rd(IDX_STATUS_HIGH, 32'h0100);
    rd(IDX_IRQ_STATUS, 32'h2);
    wr(IDX_SECTOR_SEL, 16'hC000);
    wr(IDX_OP_CONTROL, 16'h0012);
    tick(1);
    check_pin({16'h0, erase_sectors}, 32'h4000);
    idle();
    rd(IDX_IRQ_STATUS, 32'h2);
    done_test("protected_erase");
    tick(4);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
